/* File: core/dswl_pkg_rx.sv */
// Shared constants and types, plus the serial-clock receiver of the write path
package dswl_pkg;

  // Word and switch field layout
  localparam int WORD_W = 16;
  localparam int THERM_IN_W = 4;
  localparam int THERM_W = 15;
  localparam int LADDER_W = 12;
  localparam int LADDER_LSB = 0;

  // Reset values
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [THERM_W-1:0] THERM_RESET = 15'h0000;
  localparam logic [LADDER_W-1:0] LADDER_RESET = 12'h000;
  localparam logic TOGGLE_RESET = 1'b0;
  localparam logic STROBE_IDLE = 1'b1;

  // Serial-clock domain state: shift register only
  typedef struct packed {
    logic [WORD_W-1:0] shift;
  } dswl_shift_t;

  // Chip-select edge domain state: snapshot and event toggle
  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic tog;
  } dswl_frame_t;

  // Core clock domain state
  typedef struct packed {
    logic tog_s1;
    logic tog_s2;
    logic tog_prev;
    logic stb_s1;
    logic stb_s2;
    logic [WORD_W-1:0] input_word;
    logic [WORD_W-1:0] latch_code;
    logic [THERM_W-1:0] therm;
    logic [LADDER_W-1:0] ladder;
    logic word_loaded;
    logic latch_updated;
  } dswl_core_t;

endpackage : dswl_pkg

`timescale 1ns/1ps

module dswl_link_rx
  import dswl_pkg::*;
(
  // Power-on reset
  input wire logic rst_i,
  // Serial link pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  // Snapshot towards the core domain
  output logic [WORD_W-1:0] frame_word_o,
  output logic frame_toggle_o
);

  dswl_shift_t sh;
  dswl_shift_t next_sh;
  dswl_frame_t fr;
  dswl_frame_t next_fr;

  // Shift MSB first while selected; deselected edges change nothing
  always_comb begin
    next_sh = sh;
    if (!cs_n_i) begin
      next_sh.shift = {sh.shift[WORD_W-2:0], sdi_i};
    end
  end

  // No reset here: contents stay undefined until bits arrive
  always_ff @(posedge sclk_i) begin
    sh <= next_sh;
  end

  // Frame close snapshots the last 16 bits and flips the event toggle
  always_comb begin
    next_fr = fr;
    next_fr.word = sh.shift;
    next_fr.tog = ~fr.tog;
  end

  // Clocked by the chip-select rising edge; the snapshot then holds for a full frame
  always_ff @(posedge cs_n_i or posedge rst_i) begin
    if (rst_i) begin
      fr <= '{word: WORD_RESET, tog: TOGGLE_RESET};
    end else begin
      fr <= next_fr;
    end
  end

  assign frame_word_o = fr.word;
  assign frame_toggle_o = fr.tog;

endmodule : dswl_link_rx

/* File: core/dswl_write_latch.sv */
// Write path top: serial receive, input register, converter latch and switch decode
//
// Contract
// - One 16-bit word per transfer, MSB first
// - Power-on clears input register and latch
// - Shift register is not cleared at power-on
// - Short frame keeps older shift bits
// - Chip select high ignores clock and data
// - Master shifts on falling, device samples rising
// - Chip select rise copies shift to input
// - Long frame transfers the last 16 bits
// - Strobeless variant: latch loads with input register
// - Strobe low after frame updates the latch
// - Strobe tied low: latch follows each load
// - Top four bits thermometer, twelve bits ladder
// - Strobe low makes the latch transparent
`timescale 1ns/1ps

module dswl_write_latch
  import dswl_pkg::*;
#(
  parameter bit LOAD_STROBE_PRESENT = 1'b1
) (
  // Core clock and power-on reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Serial link pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  input wire logic latch_load_strobe_n_i,
  // Register contents
  output logic [WORD_W-1:0] input_word_o,
  output logic [WORD_W-1:0] latch_code_o,
  // Switch controls
  output logic [THERM_W-1:0] therm_sw_o,
  output logic [LADDER_W-1:0] ladder_sw_o,
  // Event pulses
  output logic word_loaded_o,
  output logic latch_updated_o
);

  dswl_core_t r;
  dswl_core_t next_r;
  logic [WORD_W-1:0] frame_word;
  logic frame_toggle;
  logic load;

  localparam dswl_core_t CORE_RESET = '{
    tog_s1: TOGGLE_RESET,
    tog_s2: TOGGLE_RESET,
    tog_prev: TOGGLE_RESET,
    stb_s1: STROBE_IDLE,
    stb_s2: STROBE_IDLE,
    input_word: WORD_RESET,
    latch_code: WORD_RESET,
    therm: THERM_RESET,
    ladder: LADDER_RESET,
    word_loaded: 1'b0,
    latch_updated: 1'b0
  };

  // Count of high segments: code k turns on switches 1..k
  function automatic logic [THERM_W-1:0] therm_decode(input logic [THERM_IN_W-1:0] code);
    logic [THERM_W-1:0] t;
    t = '0;
    for (int i = 0; i < THERM_W; i++) begin
      t[i] = (32'(code) > i);
    end
    return t;
  endfunction : therm_decode

  // Link-side receiver on the serial clock and chip-select edges
  dswl_link_rx u_link_rx (
    .rst_i(rst_i),
    .sclk_i(sclk_i),
    .cs_n_i(cs_n_i),
    .sdi_i(sdi_i),
    .frame_word_o(frame_word),
    .frame_toggle_o(frame_toggle)
  );

  // A toggle change marks a closed frame; the snapshot is stable long before it is seen
  assign load = r.tog_s2 ^ r.tog_prev;

  // Next-state logic
  always_comb begin
    next_r = r;
    // Two-flop synchronisers for the toggle and the strobe pin
    next_r.tog_s1 = frame_toggle;
    next_r.tog_s2 = r.tog_s1;
    next_r.tog_prev = r.tog_s2;
    next_r.stb_s1 = latch_load_strobe_n_i;
    next_r.stb_s2 = r.stb_s1;
    next_r.word_loaded = 1'b0;
    // Input register takes the frame snapshot
    if (load) begin
      next_r.input_word = frame_word;
      next_r.word_loaded = 1'b1;
    end
    // Latch path depends on the variant
    if (!LOAD_STROBE_PRESENT) begin
      if (load) begin
        next_r.latch_code = frame_word;
      end
    end else if (!r.stb_s2) begin
      // Transparent while low, so a tied-low strobe follows one cycle behind
      next_r.latch_code = r.input_word;
    end
    next_r.latch_updated = (next_r.latch_code != r.latch_code);
    // Segmented decode, registered so the switch controls never glitch
    next_r.therm = therm_decode(next_r.latch_code[WORD_W-1 -: THERM_IN_W]);
    next_r.ladder = next_r.latch_code[LADDER_LSB +: LADDER_W];
  end

  // State register; power-on gives zero code everywhere downstream of the shift
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= CORE_RESET;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from flops
  assign input_word_o = r.input_word;
  assign latch_code_o = r.latch_code;
  assign therm_sw_o = r.therm;
  assign ladder_sw_o = r.ladder;
  assign word_loaded_o = r.word_loaded;
  assign latch_updated_o = r.latch_updated;

endmodule : dswl_write_latch

/* File: testbench/dswl_master.sv */
// Serial bus master model for the link pins
`timescale 1ns/1ps
module dswl_master;
  // Link pins, idle at time zero
  logic sclk = 1'b0;
  logic cs_n = 1'b1;
  logic sdi = 1'b0;
  // Shift n bits MSB first; sel low leaves chip select high
  task automatic send(input logic [31:0] w, input int n, input bit sel);
    int i;
    #43 cs_n = !sel;
    #40;
    for (i = n - 1; i >= 0; i--) begin
      sdi = w[i];
      #40 sclk = 1'b1;
      #40 sclk = 1'b0;
    end
    sdi = ~sdi; // Released line must not hold a stale bit
    #40 cs_n = 1'b1;
  endtask : send
endmodule : dswl_master

/* File: testbench/dswl_write_latch_asserts.sv */
// Port checker for the write path
`timescale 1ns/1ps
module dswl_write_latch_asserts
  import dswl_pkg::*;
#(parameter bit LOAD_STROBE_PRESENT = 1'b1) (
  // Clock, reset and pins
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic latch_load_strobe_n_i,
  // Watched outputs
  input wire logic [WORD_W-1:0] input_word_o,
  input wire logic [WORD_W-1:0] latch_code_o,
  input wire logic [THERM_W-1:0] therm_sw_o,
  input wire logic [LADDER_W-1:0] ladder_sw_o,
  input wire logic word_loaded_o,
  input wire logic latch_updated_o
);
  // One core domain
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  a_reset_zero: assert property ($fell(rst_i) |-> (input_word_o | latch_code_o) == 16'h0000)
    else $error("not clear");
  a_cs_load: assert property ($rose(cs_n_i) |-> ##[1:4] word_loaded_o)
    else $error("no load");
  a_load_flag: assert property ($changed(input_word_o) |-> word_loaded_o)
    else $error("silent load");
  a_latch_flag: assert property ($changed(latch_code_o) |-> latch_updated_o)
    else $error("silent latch");
  a_latch_hold: assert property (LOAD_STROBE_PRESENT && $past(latch_load_strobe_n_i, 2)
    && $past(latch_load_strobe_n_i, 3) |-> $stable(latch_code_o)) else $error("latch moved");
  // Strobeless variant loads latch and input register on one edge
  a_latch_follow: assert property (latch_updated_o |-> latch_code_o ==
    (LOAD_STROBE_PRESENT ? $past(input_word_o) : input_word_o)) else $error("bad latch");
  a_ladder_bits: assert property (ladder_sw_o == latch_code_o[11:0])
    else $error("bad ladder");
  a_therm_code: assert property (therm_sw_o == 15'((16'h0001 << latch_code_o[15:12]) - 1))
    else $error("bad therm");
  // Main traffic
  c_load: cover property (word_loaded_o);
  c_latch: cover property (latch_updated_o);
  c_select: cover property (!cs_n_i);
endmodule : dswl_write_latch_asserts

bind dswl_write_latch dswl_write_latch_asserts #(.LOAD_STROBE_PRESENT(LOAD_STROBE_PRESENT)) u_chk (
  .core_clk_i, .rst_i, .cs_n_i, .latch_load_strobe_n_i, .input_word_o, .latch_code_o,
  .therm_sw_o, .ladder_sw_o, .word_loaded_o, .latch_updated_o);

/* File: testbench/testbench.sv */
// Self-checking bench for the serial write path
`timescale 1ns/1ps
module testbench;
  import dswl_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic strobe_n = 1'b1;
  logic [WORD_W-1:0] input_word_o, latch_code_o;
  logic [THERM_W-1:0] therm_sw_o;
  logic [LADDER_W-1:0] ladder_sw_o;
  logic word_loaded_o, latch_updated_o;
  logic [WORD_W-1:0] latch_code_v0;
  int errors = 0;
  int checked = 0;
  // Core clock, 20 ns period
  always #10 core_clk_i = ~core_clk_i;
  dswl_master u_dswl_master ();
  dswl_write_latch u_dswl_write_latch (.core_clk_i, .rst_i, .sclk_i(u_dswl_master.sclk),
    .cs_n_i(u_dswl_master.cs_n), .sdi_i(u_dswl_master.sdi), .latch_load_strobe_n_i(strobe_n),
    .input_word_o, .latch_code_o, .therm_sw_o, .ladder_sw_o, .word_loaded_o, .latch_updated_o);
  // Strobeless variant on the same link pins
  dswl_write_latch #(.LOAD_STROBE_PRESENT(1'b0)) u_dswl_write_latch_v0 (.core_clk_i, .rst_i,
    .sclk_i(u_dswl_master.sclk), .cs_n_i(u_dswl_master.cs_n), .sdi_i(u_dswl_master.sdi),
    .latch_load_strobe_n_i(strobe_n), .input_word_o(), .latch_code_o(latch_code_v0),
    .therm_sw_o(), .ladder_sw_o(), .word_loaded_o(), .latch_updated_o());
  // Compare one value, narrower results zero-extended
  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk
  // Bounded wait for the load pulse, then check the word
  task automatic loaded(input logic [15:0] w);
    int n;
    for (n = 0; n < 20 && word_loaded_o !== 1'b1; n++) @(posedge core_clk_i) #1;
    chk(w, input_word_o);
  endtask : loaded
  // Word loads input register; latch waits for the strobe
  task automatic t_word();
    chk(16'h0000, input_word_o | latch_code_o);
    chk(16'h0000, latch_code_v0);
    u_dswl_master.send(32'h0000_A5C3, 16, 1'b1);
    loaded(16'hA5C3);
    chk(16'hA5C3, latch_code_v0);
    chk(16'h0000, latch_code_o);
    strobe_n = 1'b0;
    repeat (4) @(posedge core_clk_i) #1;
    strobe_n = 1'b1;
    chk(16'hA5C3, latch_code_o);
    chk(16'h03FF, {1'b0, therm_sw_o});
    chk(16'h05C3, {4'h0, ladder_sw_o});
  endtask : t_word
  // Unselected clocks ignored, short frame mixes, long frame keeps last 16
  task automatic t_frames();
    u_dswl_master.send(32'h0000_FFFF, 16, 1'b0);
    u_dswl_master.send(32'h0000_005A, 8, 1'b1);
    loaded(16'hC35A);
    u_dswl_master.send(32'h000F_1234, 20, 1'b1);
    loaded(16'h1234);
  endtask : t_frames
  // Strobe tied low: latch follows each load
  task automatic t_tied();
    strobe_n = 1'b0;
    u_dswl_master.send(32'h0000_FFFF, 16, 1'b1);
    loaded(16'hFFFF);
    @(posedge core_clk_i) #1;
    chk(16'hFFFF, latch_code_o);
    chk(16'h7FFF, {1'b0, therm_sw_o});
  endtask : t_tied
  // Report counts and verdict
  task automatic summarize();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  // Main sequence after 10 reset cycles
  initial begin
    repeat (10) @(posedge core_clk_i);
    #1 rst_i = 1'b0;
    @(posedge core_clk_i) #1;
    t_word();
    t_frames();
    t_tied();
    summarize();
  end
  // Watchdog, well beyond five frames
  initial begin
    #100_000;
    errors++;
    summarize();
  end
endmodule : testbench
